// File: hdl/sms_top.sv
// Stop-mode sequencer, reset-source status and watchdog service over APB
// What this block does
// - Debug enabled at stop keeps clocks, regulator
// - Memory commands in stop report error only
// - Entry command in stop wakes into background
// - Background mode accepts every debug command
// - Deep stop powers down, latches pins
// - Reset or enabled timer wakes deep stop
// - Legacy active-low wake pin, output disables
// - Timer or wake-pin deep wake restarts like power-on
// - Deep wake forces low-voltage reset on
// - Powerdown flag, pin latch until ack
// - Read-only cause flags; forced reset clears
// - Bad watchdog address write forces reset when watchdog enabled
// - Key pair restarts watchdog, status kept
// - Flags follow sources active at entry
// - Power-on sets bits seven and one
// - Bit six marks reset pin
// - Bit five marks enabled watchdog timeout
// - Bit four marks illegal opcodes
// - Bit three marks illegal address
//
// Implementation choices: the placing of the registers and the APB interface to the registers.
`timescale 1ns/1ns
module sms_top
  import sms_pkg::*;
#(
  parameter int PIN_W = 8,
  parameter int WDOG_TIMEOUT = WDOG_TIMEOUT_CYCLES,
  parameter bit LEGACY_WAKE = 1'b1
) (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic stop_exec,
  input wire logic halt_exec,
  input wire logic illegal_opcode,
  input wire logic illegal_address,
  input wire logic clock_loss,
  input wire logic reset_pin_n,
  input wire logic low_voltage,
  input wire logic rtc_wake,
  input wire logic wake_pin_n,
  input wire logic wake_pin_is_output,
  input wire logic dbg_cmd_valid,
  input wire logic [1:0] dbg_cmd_code,
  output logic dbg_cmd_ack,
  output logic dbg_cmd_error,
  output logic dbg_mem_access,
  input wire logic [PIN_W-1:0] pin_ctrl_in,
  output logic [PIN_W-1:0] pin_ctrl_out,
  output logic pins_latched,
  output logic core_power_off,
  output logic debug_clk_on,
  output logic regulator_full,
  output logic sys_reset,
  output logic fetch_vector,
  output logic background_active
);
  if (RESET_HOLD_CYCLES < 1 || RESET_HOLD_CYCLES >= (1 << HOLD_CNT_W)) begin : g_bad_hold
    $error("sms_top: reset hold count does not fit its counter");
  end

  typedef struct packed {
    sms_state_type state;
    logic [7:0] status;
    logic wdog_en;
    logic stop_allow;
    logic deep_sel;
    logic lv_en;
    logic rtc_en;
    logic bg_en;
    logic ppd_flag;
    logic pins_latched;
    logic key_armed;
    logic [HOLD_CNT_W-1:0] hold_cnt;
    logic [31:0] prdata;
    logic pready;
    logic pslverr;
    logic dbg_ack;
    logic dbg_err;
    logic dbg_mem;
    logic core_off;
    logic dbg_clk;
    logic reg_full;
    logic sys_reset;
    logic fetch;
    logic bg_active;
  } sms_main_type;

  localparam sms_main_type MAIN_RESET = '{
    state: ST_RESET,
    status: SRS_POWER_ON_VALUE,
    wdog_en: OPT_RESET_VALUE[OPT_WATCHDOG_EN_BIT],
    stop_allow: OPT_RESET_VALUE[OPT_STOP_ALLOW_BIT],
    deep_sel: OPT_RESET_VALUE[OPT_DEEP_SELECT_BIT],
    lv_en: PM_RESET_VALUE[PM_LOW_VOLTAGE_EN_BIT],
    rtc_en: PM_RESET_VALUE[PM_RTC_WAKE_EN_BIT],
    bg_en: DBG_RESET_VALUE[DBG_ENABLE_BIT],
    dbg_clk: 1'b1,
    reg_full: 1'b1,
    sys_reset: 1'b1,
    default: '0
  };

  sms_main_type r_reg;
  sms_main_type r_next;
  logic wdog_expired;
  logic wdog_restart;

  always_comb begin
    logic setup;
    logic access;
    logic wr;
    logic [7:0] wbyte;
    logic [7:0] cause;
    logic enter_reset;
    logic deep_wake;
    logic [7:0] rdata;
    logic unmapped;
    setup = psel && !penable && !r_reg.pready;
    access = psel && penable && r_reg.pready;
    wr = access && pwrite;
    wbyte = pwdata[7:0];
    cause = 8'h00;
    enter_reset = 1'b0;
    deep_wake = 1'b0;
    rdata = 8'h00;
    unmapped = 1'b0;
    wdog_restart = 1'b0;
    r_next = r_reg;
    r_next.pready = setup;
    r_next.dbg_ack = 1'b0;
    r_next.dbg_err = 1'b0;
    r_next.dbg_mem = 1'b0;
    r_next.fetch = 1'b0;

    // Register writes; read-only fields ignore them
    if (wr) begin
      if (paddr == SMS_ADDR_STATUS) begin
        if (wbyte == WDOG_KEY_FIRST) begin
          r_next.key_armed = 1'b1;
        end else if (wbyte == WDOG_KEY_SECOND) begin
          wdog_restart = r_reg.key_armed;
          r_next.key_armed = 1'b0;
        end else begin
          r_next.key_armed = 1'b0;
          if (r_reg.wdog_en) begin
            cause[SRS_WATCHDOG_BIT] = 1'b1;
            enter_reset = 1'b1;
          end
        end
      end else if (paddr == SMS_ADDR_POWER) begin
        r_next.lv_en = wbyte[PM_LOW_VOLTAGE_EN_BIT];
        r_next.rtc_en = wbyte[PM_RTC_WAKE_EN_BIT];
        if (wbyte[PM_ACK_BIT]) begin
          r_next.ppd_flag = 1'b0;
          r_next.pins_latched = 1'b0;
        end
      end else if (paddr == SMS_ADDR_OPTIONS) begin
        r_next.wdog_en = wbyte[OPT_WATCHDOG_EN_BIT];
        r_next.stop_allow = wbyte[OPT_STOP_ALLOW_BIT];
        r_next.deep_sel = wbyte[OPT_DEEP_SELECT_BIT];
      end else if (paddr == SMS_ADDR_DEBUG) begin
        r_next.bg_en = wbyte[DBG_ENABLE_BIT];
      end else if (paddr == SMS_ADDR_FORCE) begin
        if (wbyte[FORCE_RESET_BIT]) begin
          enter_reset = 1'b1;
        end
      end
    end

    // Reset sources while the core runs, is in background or is shallow-stopped
    if (r_reg.state != ST_DEEP && r_reg.state != ST_RESET) begin
      cause[SRS_PIN_BIT] = !reset_pin_n;
      cause[SRS_WATCHDOG_BIT] = cause[SRS_WATCHDOG_BIT] || (wdog_expired && r_reg.wdog_en);
      cause[SRS_ILLEGAL_OP_BIT] = illegal_opcode || (stop_exec && !r_reg.stop_allow)
        || (halt_exec && !r_reg.bg_en);
      cause[SRS_ILLEGAL_ADDR_BIT] = illegal_address;
      cause[SRS_CLOCK_LOSS_BIT] = clock_loss;
      cause[SRS_LOW_VOLTAGE_BIT] = low_voltage && r_reg.lv_en;
      enter_reset = enter_reset || (cause != 8'h00);
    end

    // Debug link; dead while powered down or held in reset
    if (dbg_cmd_valid && (r_reg.state == ST_RUN || r_reg.state == ST_BACKGROUND)) begin
      r_next.dbg_ack = 1'b1;
      r_next.dbg_mem = (dbg_cmd_code == CMD_MEM_STATUS);
      r_next.dbg_err = (dbg_cmd_code == CMD_ENTRY) && !r_reg.bg_en && (r_reg.state == ST_RUN);
    end else if (dbg_cmd_valid && r_reg.state == ST_SHALLOW && r_reg.bg_en) begin
      r_next.dbg_ack = 1'b1;
      r_next.dbg_err = !(dbg_cmd_code == CMD_ENTRY && r_reg.bg_en);
    end

    case (r_reg.state)
      ST_RUN: begin
        if (dbg_cmd_valid && dbg_cmd_code == CMD_ENTRY && r_reg.bg_en) begin
          r_next.state = ST_BACKGROUND;
        end else if (halt_exec && r_reg.bg_en) begin
          r_next.state = ST_BACKGROUND;
        end else if (stop_exec && r_reg.stop_allow) begin
          // Debug enabled forbids deep stop so the link stays alive
          if (r_reg.deep_sel && !r_reg.bg_en) begin
            r_next.state = ST_DEEP;
            r_next.pins_latched = 1'b1;
          end else begin
            r_next.state = ST_SHALLOW;
          end
        end
      end
      ST_SHALLOW: begin
        if (dbg_cmd_valid && dbg_cmd_code == CMD_ENTRY && r_reg.bg_en) begin
          r_next.state = ST_BACKGROUND;
        end else if (rtc_wake) begin
          r_next.state = ST_RUN;
        end
      end
      ST_BACKGROUND: begin
        if (dbg_cmd_valid && dbg_cmd_code == CMD_GO) begin
          r_next.state = ST_RUN;
        end
      end
      ST_DEEP: begin
        if (!reset_pin_n) begin
          deep_wake = 1'b1;
          cause[SRS_PIN_BIT] = 1'b1;
        end else if (rtc_wake && r_reg.rtc_en) begin
          deep_wake = 1'b1;
          cause = SRS_POWER_ON_VALUE;
        end else if (LEGACY_WAKE && !wake_pin_is_output && !wake_pin_n) begin
          deep_wake = 1'b1;
          cause = SRS_POWER_ON_VALUE;
        end
      end
      ST_RESET: begin
        if (r_reg.hold_cnt != HOLD_CNT_W'(RESET_HOLD_CYCLES - 1)) begin
          r_next.hold_cnt = r_reg.hold_cnt + HOLD_CNT_W'(1);
        end else if (reset_pin_n && !(low_voltage && r_reg.lv_en)) begin
          r_next.state = ST_RUN;
          r_next.fetch = 1'b1;
        end
      end
      default: begin
        r_next.state = ST_RESET;
      end
    endcase

    if (enter_reset || deep_wake) begin
      r_next.status = cause;
      r_next.state = ST_RESET;
      r_next.hold_cnt = '0;
      r_next.wdog_en = MAIN_RESET.wdog_en;
      r_next.stop_allow = MAIN_RESET.stop_allow;
      r_next.deep_sel = MAIN_RESET.deep_sel;
      r_next.lv_en = MAIN_RESET.lv_en;
      r_next.rtc_en = MAIN_RESET.rtc_en;
      r_next.bg_en = MAIN_RESET.bg_en;
      r_next.key_armed = 1'b0;
    end
    if (deep_wake) begin
      r_next.lv_en = 1'b1;
      r_next.ppd_flag = 1'b1;
    end
    r_next.status[0] = 1'b0;

    // Read data is captured in the setup cycle and shown in the access cycle
    if (paddr == SMS_ADDR_STATUS) begin
      rdata = r_reg.status;
    end else if (paddr == SMS_ADDR_POWER) begin
      rdata[PM_LOW_VOLTAGE_EN_BIT] = r_reg.lv_en;
      rdata[PM_RTC_WAKE_EN_BIT] = r_reg.rtc_en;
      rdata[PM_FLAG_BIT] = r_reg.ppd_flag;
    end else if (paddr == SMS_ADDR_OPTIONS) begin
      rdata[OPT_WATCHDOG_EN_BIT] = r_reg.wdog_en;
      rdata[OPT_STOP_ALLOW_BIT] = r_reg.stop_allow;
      rdata[OPT_DEEP_SELECT_BIT] = r_reg.deep_sel;
    end else if (paddr == SMS_ADDR_DEBUG) begin
      rdata[DBG_ENABLE_BIT] = r_reg.bg_en;
      rdata[DBG_ACTIVE_BIT] = r_reg.bg_active;
    end else if (paddr == SMS_ADDR_FORCE) begin
      rdata = 8'h00;
    end else begin
      unmapped = 1'b1;
    end
    if (setup) begin
      r_next.prdata = pwrite ? 32'h0000_0000 : {24'h00_0000, rdata};
      r_next.pslverr = unmapped;
    end else if (!access) begin
      r_next.pslverr = 1'b0;
    end

    // Status outputs follow the next state so they leave from flip-flops
    r_next.core_off = (r_next.state == ST_DEEP);
    r_next.dbg_clk = (r_next.state != ST_DEEP)
      && !(r_next.state == ST_SHALLOW && !r_next.bg_en);
    r_next.reg_full = r_next.dbg_clk;
    r_next.sys_reset = (r_next.state == ST_RESET) || (r_next.state == ST_DEEP);
    r_next.bg_active = (r_next.state == ST_BACKGROUND);
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      r_reg <= MAIN_RESET;
    end else begin
      r_reg <= r_next;
    end
  end

  // Watchdog is cleared outside run mode and restarted while reset is held
  sms_watchdog #(
    .TIMEOUT(WDOG_TIMEOUT)
  ) u_watchdog (
    .pclk(pclk),
    .presetn(presetn),
    .enable(r_reg.wdog_en && (r_reg.state == ST_RUN)),
    .restart(wdog_restart || r_reg.sys_reset),
    .expired(wdog_expired)
  );

  // pin latch held from next state
  sms_pin_latch #(
    .WIDTH(PIN_W)
  ) u_pin_latch (
    .pclk(pclk),
    .presetn(presetn),
    .hold(r_next.pins_latched),
    .ctrl_in(pin_ctrl_in),
    .ctrl_out(pin_ctrl_out)
  );

  assign prdata = r_reg.prdata;
  assign pready = r_reg.pready;
  assign pslverr = r_reg.pslverr;
  assign dbg_cmd_ack = r_reg.dbg_ack;
  assign dbg_cmd_error = r_reg.dbg_err;
  assign dbg_mem_access = r_reg.dbg_mem;
  assign pins_latched = r_reg.pins_latched;
  assign core_power_off = r_reg.core_off;
  assign debug_clk_on = r_reg.dbg_clk;
  assign regulator_full = r_reg.reg_full;
  assign sys_reset = r_reg.sys_reset;
  assign fetch_vector = r_reg.fetch;
  assign background_active = r_reg.bg_active;
endmodule

// File: hdl/sms_pkg.sv
// Shared constants and types for the stop sequencer and reset-status block
package sms_pkg;
  // Register byte addresses on APB
  localparam logic [7:0] SMS_ADDR_STATUS = 8'h00;
  localparam logic [7:0] SMS_ADDR_POWER = 8'h04;
  localparam logic [7:0] SMS_ADDR_OPTIONS = 8'h08;
  localparam logic [7:0] SMS_ADDR_DEBUG = 8'h0c;
  localparam logic [7:0] SMS_ADDR_FORCE = 8'h10;
  // reset_source_status bit positions
  localparam int SRS_POWER_ON_BIT = 7;
  localparam int SRS_PIN_BIT = 6;
  localparam int SRS_WATCHDOG_BIT = 5;
  localparam int SRS_ILLEGAL_OP_BIT = 4;
  localparam int SRS_ILLEGAL_ADDR_BIT = 3;
  localparam int SRS_CLOCK_LOSS_BIT = 2;
  localparam int SRS_LOW_VOLTAGE_BIT = 1;
  localparam logic [7:0] SRS_POWER_ON_VALUE = 8'h82;
  // Watchdog service keys
  localparam logic [7:0] WDOG_KEY_FIRST = 8'h55;
  localparam logic [7:0] WDOG_KEY_SECOND = 8'haa;
  // power_mgmt_status_ctrl2 bits
  localparam int PM_LOW_VOLTAGE_EN_BIT = 0;
  localparam int PM_RTC_WAKE_EN_BIT = 1;
  localparam int PM_ACK_BIT = 2;
  localparam int PM_FLAG_BIT = 3;
  localparam logic [7:0] PM_RESET_VALUE = 8'h01;
  // system_options_reg bits
  localparam int OPT_DEEP_SELECT_BIT = 0;
  localparam int OPT_STOP_ALLOW_BIT = 5;
  localparam int OPT_WATCHDOG_EN_BIT = 7;
  localparam logic [7:0] OPT_RESET_VALUE = 8'h00;
  // debug_ctrl_reg bits
  localparam int DBG_ACTIVE_BIT = 6;
  localparam int DBG_ENABLE_BIT = 7;
  localparam logic [7:0] DBG_RESET_VALUE = 8'h00;
  // debug_force_reset_reg bit
  localparam int FORCE_RESET_BIT = 0;
  // Timing
  localparam int CLK_PERIOD_NS = 20;
  localparam int RESET_HOLD_NS = 160;
  localparam int RESET_HOLD_CYCLES = (RESET_HOLD_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int HOLD_CNT_W = 4;
  localparam int WDOG_TIMEOUT_CYCLES = 4096;

  typedef enum logic [2:0] {
    ST_RUN = 3'b000,
    ST_SHALLOW = 3'b001,
    ST_DEEP = 3'b010,
    ST_RESET = 3'b011,
    ST_BACKGROUND = 3'b100
  } sms_state_type;

  typedef enum logic [1:0] {
    CMD_OTHER = 2'b00,
    CMD_MEM_STATUS = 2'b01,
    CMD_ENTRY = 2'b10,
    CMD_GO = 2'b11
  } sms_cmd_type;
endpackage

// File: hdl/sms_watchdog.sv
// Watchdog timeout counter with restart
`timescale 1ns/1ns
module sms_watchdog
  import sms_pkg::*;
#(
  parameter int TIMEOUT = WDOG_TIMEOUT_CYCLES
) (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic enable,
  input wire logic restart,
  output logic expired
);
  if (TIMEOUT < 2) begin : g_bad_timeout
    $error("sms_watchdog: TIMEOUT must be at least 2");
  end

  localparam int CW = $clog2(TIMEOUT + 1);

  typedef struct packed {
    logic [CW-1:0] count;
    logic expired;
  } sms_wdog_type;

  sms_wdog_type r_reg;
  sms_wdog_type r_next;

  always_comb begin
    r_next = r_reg;
    r_next.expired = 1'b0;
    if (restart || !enable) begin
      r_next.count = '0;
    end else if (r_reg.count == CW'(TIMEOUT - 1)) begin
      r_next.count = '0;
      r_next.expired = 1'b1;
    end else begin
      r_next.count = r_reg.count + CW'(1);
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      r_reg <= '0;
    end else begin
      r_reg <= r_next;
    end
  end

  assign expired = r_reg.expired;
endmodule

// File: hdl/sms_pin_latch.sv
// Holds the I/O pin control word while powered down
`timescale 1ns/1ns
module sms_pin_latch #(
  parameter int WIDTH = 8
) (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic hold,
  input wire logic [WIDTH-1:0] ctrl_in,
  output logic [WIDTH-1:0] ctrl_out
);
  if (WIDTH < 1) begin : g_bad_width
    $error("sms_pin_latch: WIDTH must be at least 1");
  end

  typedef struct packed {
    logic [WIDTH-1:0] ctrl;
  } sms_latch_type;

  sms_latch_type r_reg;
  sms_latch_type r_next;

  always_comb begin
    r_next = r_reg;
    if (!hold) begin
      r_next.ctrl = ctrl_in;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      r_reg <= '0;
    end else begin
      r_reg <= r_next;
    end
  end

  assign ctrl_out = r_reg.ctrl;
endmodule

// File: dv/sms_dbg_host.sv
// Debug host model driving the background command link
`timescale 1ns/1ns
module sms_dbg_host
  import sms_pkg::*;
(
  input wire logic pclk,
  output logic dbg_cmd_valid,
  output logic [1:0] dbg_cmd_code,
  input wire logic dbg_cmd_ack,
  input wire logic dbg_cmd_error,
  input wire logic dbg_mem_access
);
  initial begin
    dbg_cmd_valid = 1'b0;
    dbg_cmd_code = 2'b00;
  end
  // Gap lets the host send at once or after a slow pause; resp is {ack, error, access}
  task automatic send(input sms_cmd_type code, input int gap, output logic [2:0] resp);
    int n;
    n = 0;
    repeat (gap) @(posedge pclk);
    dbg_cmd_valid <= 1'b1;
    dbg_cmd_code <= code;
    @(posedge pclk);
    dbg_cmd_valid <= 1'b0;
    // Stale code must not look like a held command
    dbg_cmd_code <= ~code;
    resp = 3'b000;
    #1;
    while (dbg_cmd_ack !== 1'b1 && n < 4) begin
      @(posedge pclk);
      #1;
      n++;
    end
    if (dbg_cmd_ack === 1'b1) begin
      resp = {1'b1, dbg_cmd_error, dbg_mem_access};
    end
    @(posedge pclk);
  endtask
endmodule

// File: dv/sms_top_props.sv
// Port-level checks for the stop sequencer
`timescale 1ns/1ns
module sms_top_props
  import sms_pkg::*;
#(
  parameter int PIN_W = 8
) (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic [31:0] prdata,
  input wire logic pready,
  input wire logic reset_pin_n,
  input wire logic dbg_cmd_valid,
  input wire logic dbg_cmd_ack,
  input wire logic dbg_cmd_error,
  input wire logic dbg_mem_access,
  input wire logic [PIN_W-1:0] pin_ctrl_out,
  input wire logic pins_latched,
  input wire logic core_power_off,
  input wire logic debug_clk_on,
  input wire logic regulator_full,
  input wire logic sys_reset,
  input wire logic fetch_vector,
  input wire logic background_active
);
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);
  chk_bg_accepts:
    assert property (background_active && dbg_cmd_valid |=> dbg_cmd_ack && !dbg_cmd_error)
    else $error("background command refused");
  chk_mem_no_err:
    assert property (dbg_mem_access |-> dbg_cmd_ack && !dbg_cmd_error)
    else $error("memory access with error");
  chk_clk_reg_pair:
    assert property (!core_power_off |-> debug_clk_on == regulator_full)
    else $error("debug clock and regulator disagree");
  chk_bg_clocked:
    assert property (background_active |-> debug_clk_on && regulator_full)
    else $error("background mode without debug clock");
  chk_deep_pins:
    assert property (core_power_off |-> pins_latched && sys_reset)
    else $error("deep stop without pin latch");
  chk_latch_frozen:
    assert property (pins_latched && $past(pins_latched) |-> $stable(pin_ctrl_out))
    else $error("latched pins moved");
  chk_latch_held:
    assert property (pins_latched && !(psel && penable && pready && pwrite
      && paddr == SMS_ADDR_POWER && pwdata[PM_ACK_BIT]) |=> pins_latched)
    else $error("pin latch dropped without ack");
  chk_pin_holds:
    assert property (sys_reset && !reset_pin_n |=> sys_reset)
    else $error("reset left while pin low");
  chk_vector_pulse:
    assert property ($fell(sys_reset) |-> ##[0:1] fetch_vector)
    else $error("no vector fetch at reset exit");
  chk_deep_silent:
    assert property (core_power_off |-> !dbg_cmd_ack)
    else $error("command acked in deep stop");
  chk_zero_bit:
    assert property (pready && !pwrite && paddr == SMS_ADDR_STATUS |->
      prdata[0] == 1'b0 && prdata[31:8] == 24'h0)
    else $error("status zero bits set");
endmodule
bind sms_top sms_top_props #(.PIN_W(PIN_W)) sms_top_props_inst (.*);

// File: dv/tb.sv
// Self-checking bench for the stop sequencer
`timescale 1ns/1ns
module tb;
  import sms_pkg::*;
  logic pclk, presetn, psel, penable, pwrite, pready, pslverr;
  logic [7:0] paddr, pin_ctrl_in, pin_ctrl_out, pat, v;
  logic [31:0] pwdata, prdata, r;
  logic stop_exec, halt_exec, illegal_opcode, illegal_address, clock_loss;
  logic reset_pin_n, low_voltage, rtc_wake, wake_pin_n, wake_pin_is_output;
  logic dbg_cmd_valid, dbg_cmd_ack, dbg_cmd_error, dbg_mem_access, e;
  logic [1:0] dbg_cmd_code;
  logic pins_latched, core_power_off, debug_clk_on, regulator_full, sys_reset;
  logic fetch_vector, background_active;
  logic [2:0] resp;
  int num_errors = 0;
  int samples_checked = 0;
  sms_top #(.WDOG_TIMEOUT(16)) sms_top_inst (.*);
  sms_dbg_host sms_dbg_host_inst (.*);
  initial begin
    pclk = 1'b0;
    forever #10 pclk = ~pclk;
  end
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    samples_checked++;
    if (got !== exp) begin
      num_errors++;
      $display("Error at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    int n;
    n = 0;
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    @(posedge pclk);
    while (pready !== 1'b1 && n < 20) begin
      @(posedge pclk);
      n++;
    end
    if (n == 20) num_errors++;
    r = prdata;
    e = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge pclk);
  endtask
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    apb(1'b1, a, {24'h0, d});
  endtask
  task automatic rd(input logic [7:0] a, input logic [7:0] exp);
    apb(1'b0, a, 32'h0);
    chk(r, {24'h0, exp});
  endtask
  task automatic cyc(input int n);
    repeat (n) @(posedge pclk);
  endtask
  // Waits for reset to start, then for it to end
  task automatic reset_cycle();
    int n;
    n = 0;
    while (sys_reset !== 1'b1 && n < 40) begin
      @(posedge pclk);
      n++;
    end
    while (sys_reset !== 1'b0 && n < 400) begin
      @(posedge pclk);
      n++;
    end
    if (n >= 400 || sys_reset !== 1'b0) num_errors++;
    cyc(1);
  endtask
  task automatic fire(input int idx);
    case (idx)
      0: illegal_opcode <= 1'b1;
      1: illegal_address <= 1'b1;
      2: clock_loss <= 1'b1;
      3: stop_exec <= 1'b1;
      default: halt_exec <= 1'b1;
    endcase
    @(posedge pclk);
    {illegal_opcode, illegal_address, clock_loss, stop_exec, halt_exec} <= 5'b0;
  endtask
  function automatic logic [7:0] src_flag(input int idx);
    if (idx == 1) return 8'h01 << SRS_ILLEGAL_ADDR_BIT;
    if (idx == 2) return 8'h01 << SRS_CLOCK_LOSS_BIT;
    return 8'h01 << SRS_ILLEGAL_OP_BIT;
  endfunction
  task automatic finish_test();
    $display("Checks: %0d compared, %0d errors", samples_checked, num_errors);
    if (num_errors == 0 && samples_checked > 0) begin
      $display("Result: passed");
    end else begin
      $display("Result: failed");
    end
    $finish;
  endtask
  initial begin
    #400000;
    num_errors++;
    finish_test();
  end
  initial begin
    {psel, penable, pwrite, paddr, pwdata, pin_ctrl_in} = '0;
    {stop_exec, halt_exec, illegal_opcode, illegal_address, clock_loss} = 5'b0;
    {low_voltage, rtc_wake, wake_pin_is_output} = 3'b0;
    {reset_pin_n, wake_pin_n} = 2'b11;
    void'($urandom(32'h1a99d84e));
    presetn = 1'b0;
    cyc(3);
    presetn <= 1'b1;
    reset_cycle();
    rd(SMS_ADDR_STATUS, SRS_POWER_ON_VALUE);
    rd(SMS_ADDR_POWER, PM_RESET_VALUE);
    rd(SMS_ADDR_OPTIONS, OPT_RESET_VALUE);
    rd(SMS_ADDR_DEBUG, DBG_RESET_VALUE);
    rd(8'h14, 8'h00);
    chk(e, 1'b1);
    $display("test reset_values done");
    wr(SMS_ADDR_STATUS, WDOG_KEY_FIRST);
    wr(SMS_ADDR_STATUS, 8'h3c);
    cyc(3);
    chk(sys_reset, 1'b0);
    rd(SMS_ADDR_STATUS, SRS_POWER_ON_VALUE);
    wr(SMS_ADDR_OPTIONS, 8'h01 << OPT_WATCHDOG_EN_BIT);
    repeat (4) begin
      cyc(4);
      wr(SMS_ADDR_STATUS, WDOG_KEY_FIRST);
      wr(SMS_ADDR_STATUS, WDOG_KEY_SECOND);
    end
    chk(sys_reset, 1'b0);
    rd(SMS_ADDR_STATUS, SRS_POWER_ON_VALUE);
    do v = 8'($urandom); while (v == WDOG_KEY_FIRST || v == WDOG_KEY_SECOND);
    wr(SMS_ADDR_STATUS, v);
    reset_cycle();
    rd(SMS_ADDR_STATUS, 8'h01 << SRS_WATCHDOG_BIT);
    wr(SMS_ADDR_OPTIONS, 8'h01 << OPT_WATCHDOG_EN_BIT);
    reset_cycle();
    rd(SMS_ADDR_STATUS, 8'h01 << SRS_WATCHDOG_BIT);
    cyc(40);
    chk(sys_reset, 1'b0);
    $display("test watchdog done");
    for (int i = 0; i < 5; i++) begin
      fire(i);
      reset_cycle();
      rd(SMS_ADDR_STATUS, src_flag(i));
    end
    reset_pin_n <= 1'b0;
    cyc(12);
    chk(sys_reset, 1'b1);
    reset_pin_n <= 1'b1;
    reset_cycle();
    rd(SMS_ADDR_STATUS, 8'h01 << SRS_PIN_BIT);
    wr(SMS_ADDR_FORCE, 8'h01);
    reset_cycle();
    rd(SMS_ADDR_STATUS, 8'h00);
    $display("test reset_sources done");
    wr(SMS_ADDR_DEBUG, 8'h80);
    wr(SMS_ADDR_OPTIONS, 8'h20);
    fire(3);
    cyc(2);
    chk({debug_clk_on, regulator_full}, 2'b11);
    sms_dbg_host_inst.send(CMD_MEM_STATUS, 0, resp);
    chk(resp, 3'b110);
    sms_dbg_host_inst.send(CMD_ENTRY, 3, resp);
    chk({resp, background_active}, 4'b1001);
    sms_dbg_host_inst.send(CMD_MEM_STATUS, 0, resp);
    chk(resp, 3'b101);
    sms_dbg_host_inst.send(CMD_GO, 1, resp);
    chk(resp, 3'b100);
    wr(SMS_ADDR_DEBUG, 8'h00);
    fire(3);
    cyc(2);
    chk({debug_clk_on, regulator_full}, 2'b00);
    sms_dbg_host_inst.send(CMD_MEM_STATUS, 0, resp);
    chk(resp, 3'b000);
    rtc_wake <= 1'b1;
    cyc(1);
    rtc_wake <= 1'b0;
    cyc(2);
    chk({debug_clk_on, regulator_full}, 2'b11);
    $display("test shallow_stop done");
    for (int k = 0; k < 3; k++) begin
      pat = 8'($urandom);
      pin_ctrl_in <= pat;
      wake_pin_is_output <= (k != 0);
      wr(SMS_ADDR_POWER, (k == 1) ? 8'h02 : 8'h00);
      wr(SMS_ADDR_OPTIONS, 8'h21);
      fire(3);
      cyc(2);
      chk({core_power_off, pins_latched, sys_reset}, 3'b111);
      pin_ctrl_in <= ~pat;
      sms_dbg_host_inst.send(CMD_ENTRY, 0, resp);
      chk(resp, 3'b000);
      chk(pin_ctrl_out, pat);
      wake_pin_n <= (k == 0) ? 1'b0 : 1'b1;
      rtc_wake <= (k == 1);
      reset_pin_n <= (k != 2);
      cyc(1);
      {wake_pin_n, rtc_wake, reset_pin_n} <= 3'b101;
      reset_cycle();
      rd(SMS_ADDR_STATUS, (k == 2) ? 8'h40 : SRS_POWER_ON_VALUE);
      rd(SMS_ADDR_POWER, 8'h09);
      rd(SMS_ADDR_OPTIONS, OPT_RESET_VALUE);
      chk(pin_ctrl_out, pat);
      wr(SMS_ADDR_POWER, 8'h05);
      cyc(2);
      chk({pins_latched, pin_ctrl_out}, {1'b0, ~pat});
      rd(SMS_ADDR_POWER, 8'h01);
    end
    wake_pin_is_output <= 1'b0;
    wake_pin_n <= 1'b0;
    wr(SMS_ADDR_OPTIONS, 8'h21);
    wake_pin_is_output <= 1'b1;
    fire(3);
    cyc(6);
    chk(core_power_off, 1'b1);
    wake_pin_n <= 1'b1;
    reset_pin_n <= 1'b0;
    cyc(1);
    reset_pin_n <= 1'b1;
    reset_cycle();
    $display("test deep_stop done");
    finish_test();
  end
endmodule
